// [bench/cimr_ctrl_model.sv]
`timescale 1ns/1ns
// ==========================================================================
// Controller model issuing mode register and calibration commands
module cimr_ctrl_model (
  input  wire logic       i_mclk,
  input  wire logic       i_mrr_valid,
  input  wire logic [7:0] i_mrr_data,
  output logic            o_mrw_valid,
  output logic            o_mrr_valid,
  output logic [5:0]      o_mr_addr,
  output logic [7:0]      o_mr_data,
  output logic            o_mpc_valid,
  output logic [6:0]      o_mpc_op
);
  initial begin
    o_mrw_valid = 1'b0;
    o_mrr_valid = 1'b0;
    o_mpc_valid = 1'b0;
    o_mr_addr   = 6'h00;
    o_mr_data   = 8'h00;
    o_mpc_op    = 7'h00;
  end

  // Released bus drops every valid and shows inverted address, data and op values
  task automatic release_bus();
    o_mrw_valid = 1'b0;
    o_mrr_valid = 1'b0;
    o_mpc_valid = 1'b0;
    o_mr_addr   = ~o_mr_addr;
    o_mr_data   = ~o_mr_data;
    o_mpc_op    = ~o_mpc_op;
  endtask

  task automatic mr_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_mrw_valid = 1'b1;
    o_mr_addr   = a;
    o_mr_data   = (a == cimr_pkg::MA_TERM_CTRL) ? {2'h0, d[5:0]} : d;
    @(posedge i_mclk);
    #1;
    release_bus();
  endtask

  task automatic mr_read(input logic [5:0] a, output logic v, output logic [7:0] d);
    @(posedge i_mclk);
    #1;
    o_mrr_valid = 1'b1;
    o_mr_addr   = a;
    @(posedge i_mclk);
    #1;
    // Answer stands for the one cycle after the taking edge
    v = i_mrr_valid;
    d = i_mrr_data;
    release_bus();
  endtask

  task automatic cal_start();
    @(posedge i_mclk);
    #1;
    o_mpc_valid = 1'b1;
    o_mpc_op    = cimr_pkg::MPC_READ_CAL;
    @(posedge i_mclk);
    #1;
    release_bus();
  endtask
endmodule

// [bench/tb_cal_invert_and_odt_mode_regs.sv]
`timescale 1ns/1ns
module tb_cal_invert_and_odt_mode_regs;
  logic       i_mclk, i_resetn, wsel, osel, pad, data_bus_inversion, mode_register_write, mode_register_read, multipurpose_command, rv, mv, cv, dmi, ckt, cst, cat, rfu, dba;
  logic [2:0] tv, ctv;
  logic [5:0] addr;
  logic [6:0] op;
  logic [7:0] wd, rd, pa, pb, inv, dq, md;
  int         mismatches = 0;
  int         n_checks = 0;

  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  cimr_ctrl_model u_ctrl (.i_mclk(i_mclk), .i_mrr_valid(rv), .i_mrr_data(rd), .o_mrw_valid(mode_register_write),
    .o_mrr_valid(mode_register_read), .o_mr_addr(addr), .o_mr_data(wd), .o_mpc_valid(multipurpose_command), .o_mpc_op(op));

  cimr_regs DUT (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_mrw_valid(mode_register_write), .i_mrr_valid(mode_register_read),
    .i_mr_addr(addr), .i_mr_data(wd), .i_mpc_valid(multipurpose_command), .i_mpc_op(op), .i_setpoint_write_select(wsel),
    .i_setpoint_operate_select(osel), .i_termination_value(tv), .i_ca_term_pad(pad), .i_cal_pattern_a(pa),
    .i_cal_pattern_b(pb), .i_dbi_enable(data_bus_inversion), .o_mrr_valid(rv), .o_mrr_data(rd), .o_upper_invert(inv),
    .o_controller_term_value(ctv), .o_controller_term_rfu(rfu), .o_clock_term_en(ckt),
    .o_chip_select_term_en(cst), .o_ca_term_en(cat), .o_cal_valid(cv), .o_cal_dq(dq),
    .o_upper_mask_inversion_pin(dmi), .o_dbi_active(dba));

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_mclk);
    #1;
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    u_ctrl.mr_read(a, mv, md);
    chk({7'h0, mv}, 8'h01, "read answer");
    chk(md, exp, "read data");
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    chk(inv, 8'h55, "invert reset");
    chk({ckt, cst, cat, rfu, 1'b0, ctv}, 8'h00, "term reset");
    rd_chk(cimr_pkg::MA_UPPER_INVERT, 8'h00);
    rd_chk(cimr_pkg::MA_VENDOR, 8'h00);
    rd_chk(6'h3F, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_cal(input logic [7:0] a, input logic [7:0] b, input logic [7:0] iv);
    int  i;
    logic bit_v;
    pa = a;
    pb = b;
    u_ctrl.cal_start();
    pa = ~a;
    pb = ~b;
    for (i = 0; i < 6 && cv !== 1'b1; i++) begin
      @(posedge i_mclk);
      #1;
    end
    if (cv !== 1'b1) begin
      mismatches++;
      $display("Error at %0t ns: calibration burst never started", $time);
      conclude();
    end
    for (i = 0; i < 16; i++) begin
      bit_v = (i < 8) ? a[i] : b[i-8];
      chk(dq, {8{bit_v}} ^ iv, "cal lines");
      chk({7'h0, dmi}, {7'h0, bit_v}, "mask pin");
      chk({6'h0, dba, cv}, 8'h01, "no inversion, valid");
      @(posedge i_mclk);
      #1;
    end
    chk({7'h0, cv}, 8'h00, "burst end");
    $display("test_cal done");
  endtask

  task automatic test_decode();
    int c;
    for (c = 0; c < 8; c++) begin
      u_ctrl.mr_write(cimr_pkg::MA_TERM_CTRL, 8'(c));
      settle();
      chk({4'h0, rfu, ctv}, (c == 7) ? 8'h08 : 8'(c) & 8'h07, "term code");
    end
    $display("test_decode done");
  endtask

  task automatic test_enables();
    int k;
    logic ck, cs, dis, valid;
    for (k = 0; k < 32; k++) begin
      {valid, pad, dis, cs, ck} = 5'(k);
      tv = valid ? 3'h4 : 3'h0;
      u_ctrl.mr_write(cimr_pkg::MA_TERM_CTRL, {2'h0, dis, cs, ck, 3'h1});
      settle();
      chk({5'h0, ckt, cst, cat}, {5'h0, valid & (ck | pad), valid & (cs | pad), valid & pad & ~dis},
          "term enables");
    end
    $display("test_enables done");
  endtask

  task automatic test_setpoint();
    tv = 3'h1;
    pad = 1'b0;
    wsel = 1'b0;
    u_ctrl.mr_write(cimr_pkg::MA_TERM_CTRL, 8'h00);
    wsel = 1'b1;
    u_ctrl.mr_write(cimr_pkg::MA_TERM_CTRL, 8'h0A);
    settle();
    chk({4'h0, ckt, ctv}, 8'h00, "inactive copy ignored");
    rd_chk(cimr_pkg::MA_TERM_CTRL, 8'h0A);
    wsel = 1'b0;
    rd_chk(cimr_pkg::MA_TERM_CTRL, 8'h00);
    osel = 1'b1;
    settle();
    chk({4'h0, ckt, ctv}, 8'h0A, "active copy one");
    u_ctrl.mr_write(cimr_pkg::MA_TERM_CTRL, 8'h13);
    settle();
    chk({3'h0, cst, ckt, ctv}, 8'h0A, "copy zero rewrite ignored");
    osel = 1'b0;
    settle();
    chk({3'h0, cst, ckt, ctv}, 8'h13, "copy zero active");
    $display("test_setpoint done");
  endtask

  task automatic test_midreset();
    u_ctrl.mr_write(cimr_pkg::MA_UPPER_INVERT, 8'hAA);
    tv = 3'h3;
    pad = 1'b1;
    u_ctrl.mr_write(cimr_pkg::MA_TERM_CTRL, 8'h1A);
    settle();
    chk({inv[7:4], 1'b0, ckt, cst, cat}, 8'hA7, "before reset");
    i_resetn = 1'b0;
    repeat (2) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    chk(inv, cimr_pkg::UPPER_INVERT_RST, "invert after reset");
    chk({ckt, cst, cat, rfu, 1'b0, ctv}, 8'h00, "term after reset");
    settle();
    chk({5'h0, ckt, cst, cat}, 8'h07, "pad terminates after reset");
    $display("test_midreset done");
  endtask

  initial begin
    {i_resetn, wsel, osel, pad, data_bus_inversion, tv} = '0;
    pa = 8'h00;
    pb = 8'h00;
    repeat (16) @(posedge i_mclk);
    #1;
    i_resetn = 1'b1;
    test_reset();
    test_cal(8'h5A, 8'h3C, 8'h55);
    data_bus_inversion = 1'b1;
    u_ctrl.mr_write(cimr_pkg::MA_UPPER_INVERT, 8'h15);
    test_cal(8'hA6, 8'hC3, 8'h15);
    test_decode();
    test_enables();
    test_setpoint();
    test_midreset();
    conclude();
  end
endmodule

// [rtl/cimr_cal_burst.sv]
`timescale 1ns/1ns
module cimr_cal_burst (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_start,
  input  wire logic [7:0] i_pat_a,
  input  wire logic [7:0] i_pat_b,
  input  wire logic [7:0] i_invert,
  output logic            o_valid,
  output logic [7:0]      o_dq,
  output logic            o_dmi
);

  // ==========================================================================
  // Sequencer
  cimr_pkg::cimr_cal_state_e state_reg, state_next;
  logic [2:0]                beat_reg,  beat_next;
  logic [7:0]                pa_reg,    pa_next;
  logic [7:0]                pb_reg,    pb_next;
  logic [7:0]                inv_reg,   inv_next;
  logic [7:0]                dq_reg,    dq_next;
  logic                      dmi_reg,   dmi_next;
  logic                      val_reg,   val_next;
  logic                      bit_now;

  always_comb begin
    state_next = state_reg;
    beat_next  = beat_reg;
    pa_next    = pa_reg;
    pb_next    = pb_reg;
    inv_next   = inv_reg;
    bit_now    = 1'b0;
    case (state_reg)
      cimr_pkg::CAL_IDLE: begin
        if (i_start) begin
          state_next = cimr_pkg::CAL_PAT_A;
          beat_next  = 3'h0;
          pa_next    = i_pat_a;
          pb_next    = i_pat_b;
          inv_next   = i_invert;
        end
      end
      cimr_pkg::CAL_PAT_A: begin
        bit_now   = pa_reg[beat_reg];
        beat_next = beat_reg + 3'h1;
        if (beat_reg == cimr_pkg::LAST_BEAT) begin
          state_next = cimr_pkg::CAL_PAT_B;
        end
      end
      cimr_pkg::CAL_PAT_B: begin
        bit_now   = pb_reg[beat_reg];
        beat_next = beat_reg + 3'h1;
        if (beat_reg == cimr_pkg::LAST_BEAT) begin
          state_next = cimr_pkg::CAL_IDLE;
        end
      end
      default: begin
        state_next = cimr_pkg::CAL_IDLE;
      end
    endcase
    val_next = (state_reg != cimr_pkg::CAL_IDLE);
    dq_next  = {cimr_pkg::PAT_BITS{bit_now}} ^ inv_reg;
    dmi_next = bit_now;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      state_reg <= cimr_pkg::CAL_IDLE;
      beat_reg  <= 3'h0;
      pa_reg    <= 8'h00;
      pb_reg    <= 8'h00;
      inv_reg   <= 8'h00;
      dq_reg    <= 8'h00;
      dmi_reg   <= 1'b0;
      val_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      beat_reg  <= beat_next;
      pa_reg    <= pa_next;
      pb_reg    <= pb_next;
      inv_reg   <= inv_next;
      dq_reg    <= dq_next;
      dmi_reg   <= dmi_next;
      val_reg   <= val_next;
    end
  end

  assign o_valid = val_reg;
  assign o_dq    = dq_reg;
  assign o_dmi   = dmi_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_dq_inv_xor: assert property (o_valid |-> (o_dq == ({8{o_dmi}} ^ inv_reg)))
    else $error("Driven line differs from pattern xor invert");
  a_burst_order: assert property (($rose(state_reg == cimr_pkg::CAL_PAT_A))
    |-> ##1 (o_dmi == pa_reg[0]) ##8 (o_dmi == pb_reg[0]))
    else $error("Pattern A then B order broken");
  a_burst_len: assert property ((state_reg == cimr_pkg::CAL_IDLE) && i_start
    |-> ##2 o_valid [*8] ##0 1'b1)
    else $error("Burst shorter than expected");
  c_burst_done: cover property (state_reg == cimr_pkg::CAL_PAT_B ##1 state_reg == cimr_pkg::CAL_IDLE);

endmodule

// [rtl/cimr_pkg.sv]
package cimr_pkg;

  // ==========================================================================
  // Mode register addresses
  localparam logic [5:0] MA_UPPER_INVERT = 6'h14;
  localparam logic [5:0] MA_VENDOR       = 6'h15;
  localparam logic [5:0] MA_TERM_CTRL    = 6'h16;

  // ==========================================================================
  // Reset values and vendor read value
  localparam logic [7:0] UPPER_INVERT_RST = 8'h55;
  localparam logic [7:0] TERM_CTRL_RST    = 8'h00;
  localparam logic [7:0] VENDOR_READ_VAL  = 8'h00;

  // ==========================================================================
  // Termination control field positions
  localparam int CTRL_TERM_LSB  = 0;
  localparam int CTRL_TERM_W    = 3;
  localparam int CK_OVR_BIT     = 3;
  localparam int CS_OVR_BIT     = 4;
  localparam int CA_DIS_BIT     = 5;
  localparam int BYTE_DIS_LO    = 6;
  localparam int BYTE_DIS_HI    = 7;

  // ==========================================================================
  // Controller termination codes
  localparam logic [2:0] CTRL_TERM_OFF = 3'h0;
  localparam logic [2:0] CTRL_TERM_RFU = 3'h7;

  // ==========================================================================
  // Commands and burst
  localparam logic [6:0] MPC_READ_CAL = 7'h43;
  localparam int         PAT_BITS     = 8;
  localparam logic [2:0] LAST_BEAT    = 3'h7;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic       byte_dis_hi;
    logic       byte_dis_lo;
    logic       ca_dis;
    logic       cs_ovr;
    logic       ck_ovr;
    logic [2:0] ctrl_term;
  } cimr_term_ctrl_s;

  typedef struct packed {
    logic       ck;
    logic       cs;
    logic       ca;
  } cimr_term_en_s;

  typedef enum logic [1:0] {
    CAL_IDLE  = 2'h0,
    CAL_PAT_A = 2'h1,
    CAL_PAT_B = 2'h3
  } cimr_cal_state_e;

endpackage

// [rtl/cimr_regs.sv]
`timescale 1ns/1ns
// Operation
// - Each upper invert bit set to one inverts the calibration pattern on its upper data line.
// - The upper invert register resets to 55 hex.
// - Invert bits 0-3 map to lines 8-11 and bits 4-7 to lines 12-15 in ascending order.
// - The upper mask/inversion pin always carries the true pattern bits.
// - No data bus inversion is applied during calibration readout, whatever the config says.
// - Controller termination code 0 is off, 1-6 select reference divided by 1-6, 7 is reserved.
// - Clock override set terminates clock at the configured value regardless of the pad.
// - Chip-select override set terminates chip select at the configured value regardless of the pad.
// - With CA disable clear, CA terminates only when the pad is high and the value is valid.
// - With CA disable set, CA is never terminated.
// - Termination control has two set-point copies; writes and reads reach the write-selected one.
// - Only the operate-selected copy drives behaviour; the other is ignored.
// - Termination stays on in every power state, self-refresh and power-down included.
// - The read-calibration command returns pattern A then pattern B with inversion applied.
module cimr_regs (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_mrw_valid,
  input  wire logic       i_mrr_valid,
  input  wire logic [5:0] i_mr_addr,
  input  wire logic [7:0] i_mr_data,
  input  wire logic       i_mpc_valid,
  input  wire logic [6:0] i_mpc_op,
  input  wire logic       i_setpoint_write_select,
  input  wire logic       i_setpoint_operate_select,
  input  wire logic [2:0] i_termination_value,
  input  wire logic       i_ca_term_pad,
  input  wire logic [7:0] i_cal_pattern_a,
  input  wire logic [7:0] i_cal_pattern_b,
  input  wire logic       i_dbi_enable,
  output logic            o_mrr_valid,
  output logic [7:0]      o_mrr_data,
  output logic [7:0]      o_upper_invert,
  output logic [2:0]      o_controller_term_value,
  output logic            o_controller_term_rfu,
  output logic            o_clock_term_en,
  output logic            o_chip_select_term_en,
  output logic            o_ca_term_en,
  output logic            o_cal_valid,
  output logic [7:0]      o_cal_dq,
  output logic            o_upper_mask_inversion_pin,
  output logic            o_dbi_active
);

  // ==========================================================================
  // Decode helpers
  function automatic logic term_value_valid(input logic [2:0] code);
    term_value_valid = (code != cimr_pkg::CTRL_TERM_OFF);
  endfunction

  function automatic logic [2:0] ctrl_term_div(input logic [2:0] code);
    if (code == cimr_pkg::CTRL_TERM_RFU) begin
      ctrl_term_div = cimr_pkg::CTRL_TERM_OFF;
    end else begin
      ctrl_term_div = code;
    end
  endfunction

  // ==========================================================================
  // Mode register storage
  logic [7:0]                 upper_invert_reg, upper_invert_next;
  cimr_pkg::cimr_term_ctrl_s  term_ctrl_reg  [2];
  cimr_pkg::cimr_term_ctrl_s  term_ctrl_next [2];
  logic                       mrr_valid_reg,    mrr_valid_next;
  logic [7:0]                 mrr_data_reg,     mrr_data_next;

  always_comb begin
    upper_invert_next = upper_invert_reg;
    term_ctrl_next[0] = term_ctrl_reg[0];
    term_ctrl_next[1] = term_ctrl_reg[1];
    mrr_valid_next    = i_mrr_valid;
    mrr_data_next     = 8'h00;
    if (i_mrw_valid) begin
      if (i_mr_addr == cimr_pkg::MA_UPPER_INVERT) begin
        upper_invert_next = i_mr_data;
      end
      if (i_mr_addr == cimr_pkg::MA_TERM_CTRL) begin
        term_ctrl_next[i_setpoint_write_select] = i_mr_data;
      end
    end
    if (i_mrr_valid) begin
      case (i_mr_addr)
        cimr_pkg::MA_TERM_CTRL: mrr_data_next = term_ctrl_reg[i_setpoint_write_select];
        cimr_pkg::MA_VENDOR:    mrr_data_next = cimr_pkg::VENDOR_READ_VAL;
        default:                mrr_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      upper_invert_reg <= cimr_pkg::UPPER_INVERT_RST;
      term_ctrl_reg[0] <= cimr_pkg::TERM_CTRL_RST;
      term_ctrl_reg[1] <= cimr_pkg::TERM_CTRL_RST;
      mrr_valid_reg    <= 1'b0;
      mrr_data_reg     <= 8'h00;
    end else begin
      upper_invert_reg <= upper_invert_next;
      term_ctrl_reg[0] <= term_ctrl_next[0];
      term_ctrl_reg[1] <= term_ctrl_next[1];
      mrr_valid_reg    <= mrr_valid_next;
      mrr_data_reg     <= mrr_data_next;
    end
  end

  // ==========================================================================
  // Termination control, no power-state input gates it
  cimr_pkg::cimr_term_ctrl_s  act;
  cimr_pkg::cimr_term_en_s    term_reg, term_next;
  logic [2:0]                 ctv_reg,  ctv_next;
  logic                       rfu_reg,  rfu_next;
  logic                       tv_ok;

  always_comb begin
    act          = term_ctrl_reg[i_setpoint_operate_select];
    tv_ok        = term_value_valid(i_termination_value);
    ctv_next     = ctrl_term_div(act.ctrl_term);
    rfu_next     = (act.ctrl_term == cimr_pkg::CTRL_TERM_RFU);
    term_next.ck = tv_ok && (act.ck_ovr || i_ca_term_pad);
    term_next.cs = tv_ok && (act.cs_ovr || i_ca_term_pad);
    term_next.ca = !act.ca_dis && i_ca_term_pad && tv_ok;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      term_reg <= '0;
      ctv_reg  <= cimr_pkg::CTRL_TERM_OFF;
      rfu_reg  <= 1'b0;
    end else begin
      term_reg <= term_next;
      ctv_reg  <= ctv_next;
      rfu_reg  <= rfu_next;
    end
  end

  // ==========================================================================
  // Calibration readout
  cimr_cal_burst u_cal (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_start  (i_mpc_valid && (i_mpc_op == cimr_pkg::MPC_READ_CAL)),
    .i_pat_a  (i_cal_pattern_a),
    .i_pat_b  (i_cal_pattern_b),
    .i_invert (upper_invert_reg),
    .o_valid  (o_cal_valid),
    .o_dq     (o_cal_dq),
    .o_dmi    (o_upper_mask_inversion_pin)
  );

  assign o_dbi_active            = 1'b0;
  assign o_mrr_valid             = mrr_valid_reg;
  assign o_mrr_data              = mrr_data_reg;
  assign o_upper_invert          = upper_invert_reg;
  assign o_controller_term_value = ctv_reg;
  assign o_controller_term_rfu   = rfu_reg;
  assign o_clock_term_en         = term_reg.ck;
  assign o_chip_select_term_en   = term_reg.cs;
  assign o_ca_term_en            = term_reg.ca;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_invert_reset: assert property ($rose(i_resetn) |-> (o_upper_invert == 8'h55))
    else $error("Invert register not 55 after reset");
  a_invert_write: assert property (i_mrw_valid && (i_mr_addr == cimr_pkg::MA_UPPER_INVERT)
    |=> (o_upper_invert == $past(i_mr_data)))
    else $error("Invert write lost");
  a_copy_write_sel: assert property (i_mrw_valid && (i_mr_addr == cimr_pkg::MA_TERM_CTRL)
    |=> (term_ctrl_reg[!$past(i_setpoint_write_select)] ==
         $past(term_ctrl_reg[!i_setpoint_write_select])))
    else $error("Unselected set point copy changed");
  a_mrr_copy_read: assert property (i_mrr_valid && (i_mr_addr == cimr_pkg::MA_TERM_CTRL) && !i_mrw_valid
    |=> o_mrr_valid && (o_mrr_data == $past(term_ctrl_reg[i_setpoint_write_select])))
    else $error("Read returned wrong set point copy");
  a_ca_disable_off: assert property ($past(act.ca_dis) |-> !o_ca_term_en)
    else $error("CA terminated while disabled");
  a_ca_pad_follow: assert property (!act.ca_dis && i_ca_term_pad && tv_ok |=> o_ca_term_en)
    else $error("CA not terminated with pad high");
  a_ck_override_on: assert property (act.ck_ovr && tv_ok && !i_ca_term_pad |=> o_clock_term_en)
    else $error("Clock override ignored");
  a_cs_override_on: assert property (act.cs_ovr && tv_ok && !i_ca_term_pad |=> o_chip_select_term_en)
    else $error("Chip select override ignored");
  a_ctrl_term_code: assert property ((act.ctrl_term inside {[3'h1:3'h6]})
    |=> (o_controller_term_value == $past(act.ctrl_term)) && !o_controller_term_rfu)
    else $error("Controller termination decode wrong");
  a_no_dbi_cal: assert property (i_dbi_enable && o_cal_valid |-> !o_dbi_active)
    else $error("Inversion applied during calibration");

  // ==========================================================================
  // Termination, readback and invert hold checks
  a_ca_pad_low: assert property (!i_ca_term_pad |=> !o_ca_term_en)
    else $error("CA terminated with pad low");
  a_value_off: assert property (!tv_ok
    |=> !(o_clock_term_en || o_chip_select_term_en || o_ca_term_en))
    else $error("Terminated without a valid value");
  a_ck_pad_only: assert property (!act.ck_ovr && !i_ca_term_pad |=> !o_clock_term_en)
    else $error("Clock terminated without override or pad");
  a_cs_pad_only: assert property (!act.cs_ovr && !i_ca_term_pad
    |=> !o_chip_select_term_en)
    else $error("Chip select terminated without override or pad");
  a_pad_high_on: assert property (tv_ok && i_ca_term_pad
    |=> o_clock_term_en && o_chip_select_term_en)
    else $error("Clock or chip select not terminated with pad high");
  a_rfu_code: assert property ((act.ctrl_term == cimr_pkg::CTRL_TERM_RFU)
    |=> o_controller_term_rfu && (o_controller_term_value == cimr_pkg::CTRL_TERM_OFF))
    else $error("Reserved controller code not flagged");
  a_off_code: assert property ((act.ctrl_term == cimr_pkg::CTRL_TERM_OFF)
    |=> !o_controller_term_rfu && (o_controller_term_value == cimr_pkg::CTRL_TERM_OFF))
    else $error("Disabled controller code decoded wrong");
  a_mrr_pulse: assert property (!i_mrr_valid |=> !o_mrr_valid)
    else $error("Read answer without a read");
  a_invert_hold: assert property (!(i_mrw_valid && (i_mr_addr == cimr_pkg::MA_UPPER_INVERT))
    |=> $stable(o_upper_invert))
    else $error("Invert register changed without a write");
  a_term_steady: assert property ($past(i_resetn) && $stable(act)
    && $stable(i_termination_value) && $stable(i_ca_term_pad) |=> $stable(term_reg))
    else $error("Termination changed with steady inputs");

  c_cal_read:  cover property (i_mpc_valid && (i_mpc_op == cimr_pkg::MPC_READ_CAL));
  c_sp1_write: cover property (i_mrw_valid && (i_mr_addr == cimr_pkg::MA_TERM_CTRL) && i_setpoint_write_select);
  c_ca_term:   cover property (o_ca_term_en);
  c_ck_ovr:    cover property (o_clock_term_en && !i_ca_term_pad);

endmodule
